// ### rtl/usart_dev.sv
// Device end: control write sequencing, command bits and status byte.
// Assumes bus pins synchronous to ref_clk; serial engine on user side.
`timescale 1ns/100ps
//
// Contract
// - Host inits with three zeros, then reset
// - After setup, control writes load commands
// - Host adds error clear with rx hunt
// - Control-select read returns status byte
// - Status frozen during a status read
// - Status reflects events within 28 clocks
// - Status flags mirror pins, except transmitter ready
// - Parity error sticky until error clear
// - Overrun on unread character, old lost
// - Framing error async only, sticky
// - Data set ready flag is inverted pin
// - Ready flag equals transmit buffer empty
// - Ready pin needs empty, clear-to-send, enable
// - Host writes data only when ready
// - Host keeps write recovery spacing
// - Reset held six clocks, clock running
// - Serial clocks slow enough versus system
// - External sync clock ratio above 34
// - Any reset returns to mode expected
// - Status read clears sync detect
module usart_dev (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host bus
  usart_bus_if.dev bus,
  // Receive engine events
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  input wire logic sync_det_evt,
  // Transmit engine handshake
  input wire logic tx_taken,
  input wire logic tx_shift_empty,
  // Modem inputs
  input wire logic dsr_n,
  input wire logic cts_n,
  // Configuration to the engines
  output logic [7:0] mode_byte,
  output logic [7:0] sync_char1,
  output logic [7:0] sync_char2,
  output logic [7:0] cmd_bits,
  output logic hunt,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  // Flag pins
  output logic rxrdy_pin,
  output logic txempty_pin,
  output logic syndet_pin,
  output logic dtr_n,
  output logic rts_n
);
  usart_pkg::ctl_phase_t phase_r;
  logic wr_prev_r, rd_prev_r;
  logic [7:0] mode_r, sync1_r, sync2_r, cmd_r, rx_buf_r, tx_buf_r;
  logic tx_full_r, rxrdy_r, pe_r, oe_r, fe_r, syndet_r, hunt_r;
  logic txrdy_pin_r, txempty_r, dtr_n_r, rts_n_r;
  logic [7:0] status_r, status_nxt, dout_r;
  logic dout_oe_n_r;
  logic wr_act, rd_act, wr_start, rd_start;
  logic ctl_wr, dat_wr, stat_rd, dat_rd;
  logic cmd_wr, soft_rst, go_mode, err_clr, sync_mode;

  // Strobe edges on the host bus
  assign wr_act = ~bus.cs_n & ~bus.wr_n;
  assign rd_act = ~bus.cs_n & ~bus.rd_n;
  assign wr_start = wr_act & ~wr_prev_r;
  assign rd_start = rd_act & ~rd_prev_r;
  assign ctl_wr = wr_start & bus.cd;
  assign dat_wr = wr_start & ~bus.cd;
  assign stat_rd = rd_start & bus.cd;
  assign dat_rd = rd_start & ~bus.cd;
  assign cmd_wr = ctl_wr & (phase_r == usart_pkg::PH_CMD);
  assign soft_rst = cmd_wr & bus.data_bus[usart_pkg::CMD_INT_RESET];
  assign go_mode = bus.ext_reset | soft_rst;
  assign err_clr = cmd_wr & bus.data_bus[usart_pkg::CMD_ERR_CLR];
  assign sync_mode = (mode_r[usart_pkg::MODE_RATE_HI:
                             usart_pkg::MODE_RATE_LO] == 2'b00);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
    end else begin
      wr_prev_r <= wr_act;
      rd_prev_r <= rd_act;
    end
  end

  // Control write sequencing: mode, sync characters, then commands
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= usart_pkg::PH_MODE;
      mode_r <= 8'h00;
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else if (go_mode) begin
      phase_r <= usart_pkg::PH_MODE;
    end else if (ctl_wr) begin
      case (phase_r)
        usart_pkg::PH_MODE: begin
          mode_r <= bus.data_bus;
          phase_r <= (bus.data_bus[1:0] == 2'b00) ?
                     usart_pkg::PH_SYNC1 : usart_pkg::PH_CMD;
        end
        usart_pkg::PH_SYNC1: begin
          sync1_r <= bus.data_bus;
          phase_r <= mode_r[usart_pkg::MODE_SINGLE_SYNC] ?
                     usart_pkg::PH_CMD : usart_pkg::PH_SYNC2;
        end
        usart_pkg::PH_SYNC2: begin
          sync2_r <= bus.data_bus;
          phase_r <= usart_pkg::PH_CMD;
        end
        usart_pkg::PH_CMD: phase_r <= usart_pkg::PH_CMD;
        default: phase_r <= usart_pkg::PH_MODE;
      endcase
    end
  end

  // Command register and hunt state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= 8'h00;
      hunt_r <= 1'b0;
    end else if (go_mode) begin
      cmd_r <= 8'h00;
      hunt_r <= 1'b0;
    end else if (cmd_wr) begin
      cmd_r <= bus.data_bus;
      hunt_r <= bus.data_bus[usart_pkg::CMD_HUNT] & sync_mode;
    end else if (sync_det_evt) begin
      hunt_r <= 1'b0;
    end
  end

  // Receive buffer and sticky flags; an event beats its clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buf_r <= 8'h00;
      rxrdy_r <= 1'b0;
      pe_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
      syndet_r <= 1'b0;
    end else if (go_mode) begin
      rxrdy_r <= 1'b0;
      pe_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
      syndet_r <= 1'b0;
    end else begin
      if (rx_char_valid) begin
        rx_buf_r <= rx_char;
      end
      rxrdy_r <= rx_char_valid | (rxrdy_r & ~dat_rd);
      pe_r <= (rx_char_valid & rx_parity_err) | (pe_r & ~err_clr);
      oe_r <= (rx_char_valid & rxrdy_r & ~dat_rd) | (oe_r & ~err_clr);
      fe_r <= (rx_char_valid & rx_framing_err & ~sync_mode)
              | (fe_r & ~err_clr);
      syndet_r <= sync_det_evt | (syndet_r & ~stat_rd);
    end
  end

  // Transmit buffer; a new write wins over a take in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_buf_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (bus.ext_reset) begin
      tx_full_r <= 1'b0;
    end else if (dat_wr) begin
      tx_buf_r <= bus.data_bus;
      tx_full_r <= 1'b1;
    end else if (tx_taken) begin
      tx_full_r <= 1'b0;
    end
  end

  // Pins, registered; transmitter ready also needs clear-to-send and enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txrdy_pin_r <= 1'b0;
      txempty_r <= 1'b1;
      dtr_n_r <= 1'b1;
      rts_n_r <= 1'b1;
    end else begin
      txrdy_pin_r <= ~tx_full_r & ~cts_n
                     & cmd_r[usart_pkg::CMD_TX_EN];
      txempty_r <= ~tx_full_r & tx_shift_empty;
      dtr_n_r <= ~cmd_r[usart_pkg::CMD_DTR];
      rts_n_r <= ~cmd_r[usart_pkg::CMD_RTS];
    end
  end

  // Status byte assembly
  always_comb begin
    status_nxt = 8'h00;
    status_nxt[usart_pkg::ST_TXRDY] = ~tx_full_r;
    status_nxt[usart_pkg::ST_RXRDY] = rxrdy_r;
    status_nxt[usart_pkg::ST_TXEMPTY] = txempty_r;
    status_nxt[usart_pkg::ST_PE] = pe_r;
    status_nxt[usart_pkg::ST_OE] = oe_r;
    status_nxt[usart_pkg::ST_FE] = fe_r;
    status_nxt[usart_pkg::ST_SYNDET] = syndet_r;
    status_nxt[usart_pkg::ST_DSR] = ~dsr_n;
  end

  // Visible status follows within a clock, except while a control-select (status) read holds it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= usart_pkg::STATUS_RESET;
    end else if (!(rd_act & bus.cd)) begin
      status_r <= status_nxt;
    end
  end

  // Read data driver
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_r <= 8'h00;
      dout_oe_n_r <= 1'b1;
    end else begin
      dout_oe_n_r <= ~rd_act;
      if (rd_start) begin
        dout_r <= bus.cd ? status_r : rx_buf_r;
      end
    end
  end

  assign bus.dev_d = dout_r;
  assign bus.dev_d_oe_n = dout_oe_n_r;
  assign bus.txrdy = txrdy_pin_r;
  assign mode_byte = mode_r;
  assign sync_char1 = sync1_r;
  assign sync_char2 = sync2_r;
  assign cmd_bits = cmd_r;
  assign hunt = hunt_r;
  assign tx_char = tx_buf_r;
  assign tx_char_valid = tx_full_r;
  assign rxrdy_pin = rxrdy_r;
  assign txempty_pin = txempty_r;
  assign syndet_pin = syndet_r;
  assign dtr_n = dtr_n_r;
  assign rts_n = rts_n_r;
endmodule

// ### rtl/usart_pkg.sv
// Shared constants for the serial transceiver command/status front end.
// Assumes both bus ends run on the same 100 MHz ref_clk.
package usart_pkg;
  // Clock and timing (times counted in system clock periods)
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned REC_INIT_PERIODS = 6;
  localparam int unsigned REC_ASYNC_PERIODS = 8;
  localparam int unsigned REC_SYNC_PERIODS = 16;
  localparam int unsigned RESET_PERIODS = 6;
  localparam int unsigned SER_MIN_1X_PERIODS = 30;
  localparam int unsigned EXT_SYNC_RATIO = 34;
  localparam int unsigned STATUS_MAX_PERIODS = 28;
  localparam logic [4:0] REC_INIT_CYC = 5'(REC_INIT_PERIODS);
  localparam logic [4:0] REC_ASYNC_CYC = 5'(REC_ASYNC_PERIODS);
  localparam logic [4:0] REC_SYNC_CYC = 5'(REC_SYNC_PERIODS);
  localparam logic [4:0] RESET_CYC = 5'(RESET_PERIODS);
  localparam logic [4:0] STROBE_CYC = 5'h03;
  // Serial clock divider: period above both the 1x floor and sync ratio
  localparam int unsigned SER_DIV_PERIODS = EXT_SYNC_RATIO + 2;
  localparam logic [5:0] SER_HALF_CYC = 6'(SER_DIV_PERIODS / 2);
  // Mode byte fields
  localparam int unsigned MODE_RATE_LO = 0;
  localparam int unsigned MODE_RATE_HI = 1;
  localparam int unsigned MODE_EXT_SYNC = 6;
  localparam int unsigned MODE_SINGLE_SYNC = 7;
  // Command byte fields
  localparam int unsigned CMD_TX_EN = 0;
  localparam int unsigned CMD_DTR = 1;
  localparam int unsigned CMD_RX_EN = 2;
  localparam int unsigned CMD_BREAK = 3;
  localparam int unsigned CMD_ERR_CLR = 4;
  localparam int unsigned CMD_RTS = 5;
  localparam int unsigned CMD_INT_RESET = 6;
  localparam int unsigned CMD_HUNT = 7;
  localparam logic [7:0] INIT_ZERO = 8'h00;
  localparam logic [7:0] INT_RESET_CMD = 8'h40;
  localparam logic [2:0] INIT_WRITES = 3'h4;
  // Status byte fields
  localparam int unsigned ST_TXRDY = 0;
  localparam int unsigned ST_RXRDY = 1;
  localparam int unsigned ST_TXEMPTY = 2;
  localparam int unsigned ST_PE = 3;
  localparam int unsigned ST_OE = 4;
  localparam int unsigned ST_FE = 5;
  localparam int unsigned ST_SYNDET = 6;
  localparam int unsigned ST_DSR = 7;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] BUS_IDLE = 8'hff;
  // Control write phases of the device
  typedef enum logic [1:0] {
    PH_MODE = 2'b00,
    PH_SYNC1 = 2'b01,
    PH_SYNC2 = 2'b10,
    PH_CMD = 2'b11
  } ctl_phase_t;
  // Host bus sequencer states
  typedef enum logic [1:0] {
    H_RST = 2'b00,
    H_IDLE = 2'b01,
    H_STB = 2'b10,
    H_GAP = 2'b11
  } host_state_t;
endpackage

// ### rtl/usart_bus_if.sv
// Byte-wide host bus between the transceiver and its host.
// Assumes one clock; the two-way data bus is resolved here from enables.
`timescale 1ns/100ps
interface usart_bus_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cd;
  logic ext_reset;
  logic txrdy;
  logic [7:0] host_d;
  logic host_d_oe_n;
  logic [7:0] dev_d;
  logic dev_d_oe_n;
  logic [7:0] data_bus;
  // Wire level from whichever end enables its driver
  assign data_bus = !dev_d_oe_n ? dev_d :
                    (!host_d_oe_n ? host_d : usart_pkg::BUS_IDLE);
  modport dev (
    input cs_n, rd_n, wr_n, cd, ext_reset, data_bus,
    output dev_d, dev_d_oe_n, txrdy
  );
  modport host (
    output cs_n, rd_n, wr_n, cd, ext_reset, host_d, host_d_oe_n,
    input data_bus, txrdy
  );
endinterface

// ### rtl/usart_host.sv
// Host end: bus sequencer with reset pulse, init and write pacing.
// Assumes the device end samples the bus pins on the same ref_clk.
`timescale 1ns/100ps
module usart_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host bus
  usart_bus_if.host bus,
  // Request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_cd,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic req_refused,
  // Answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Serial clock for the engines
  output logic ser_clk
);
  usart_pkg::host_state_t state_r;
  logic [4:0] cnt_r, gap_r;
  logic [2:0] init_idx_r;
  logic ready_r, refused_r, rsp_valid_r, ser_clk_r;
  logic [7:0] rsp_r, dout_r, wdata;
  logic cs_n_r, rd_n_r, wr_n_r, cd_r, doe_n_r, rst_r, is_rd_r;
  logic mode_next_r, sync_r;
  logic [1:0] left_r;
  logic [5:0] div_r;
  logic launch, l_write, l_cd, init_go, take;
  logic [7:0] l_data;

  assign init_go = (state_r == usart_pkg::H_IDLE)
                   & (init_idx_r != usart_pkg::INIT_WRITES);
  assign take = (state_r == usart_pkg::H_IDLE) & ~init_go & ready_r
                & req_valid;
  // Data writes are refused while the ready pin is low
  assign launch = init_go | (take & ~(req_write & ~req_cd
                                      & ~bus.txrdy));
  // Error clear forced with receive enable and hunt
  always_comb begin
    wdata = req_data;
    if (req_cd & req_data[usart_pkg::CMD_RX_EN]
        & req_data[usart_pkg::CMD_HUNT] & ~mode_next_r & (left_r == 2'b00))
    begin
      wdata[usart_pkg::CMD_ERR_CLR] = 1'b1;
    end
  end
  assign l_write = init_go | req_write;
  assign l_cd = init_go | req_cd;
  assign l_data = init_go ? ((init_idx_r == 3'h3) ? usart_pkg::INT_RESET_CMD
                             : usart_pkg::INIT_ZERO) : wdata;

  // Track the device setup phase to pick write spacing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_next_r <= 1'b1;
      left_r <= 2'b00;
      sync_r <= 1'b0;
    end else if (launch & l_write & l_cd) begin
      if (mode_next_r) begin
        mode_next_r <= 1'b0;
        sync_r <= (l_data[1:0] == 2'b00);
        left_r <= (l_data[1:0] != 2'b00) ? 2'b00 :
                  (l_data[usart_pkg::MODE_SINGLE_SYNC] ? 2'b01 : 2'b10);
      end else if (left_r != 2'b00) begin
        left_r <= left_r - 2'b01;
      end else if (l_data[usart_pkg::CMD_INT_RESET]) begin
        mode_next_r <= 1'b1;
      end
    end
  end

  // Bus sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= usart_pkg::H_RST;
      cnt_r <= 5'h00;
      gap_r <= usart_pkg::REC_INIT_CYC;
      init_idx_r <= 3'h0;
      ready_r <= 1'b0;
      refused_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r <= 8'h00;
      dout_r <= 8'h00;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      cd_r <= 1'b0;
      doe_n_r <= 1'b1;
      rst_r <= 1'b1;
      is_rd_r <= 1'b0;
    end else begin
      refused_r <= take & ~launch;
      rsp_valid_r <= 1'b0;
      case (state_r)
        usart_pkg::H_RST: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == usart_pkg::RESET_CYC - 5'h01) begin
            rst_r <= 1'b0;
            cnt_r <= 5'h00;
            state_r <= usart_pkg::H_IDLE;
          end
        end
        usart_pkg::H_IDLE: begin
          if (launch) begin
            ready_r <= 1'b0;
            if (init_go) begin
              init_idx_r <= init_idx_r + 3'h1;
            end
            cs_n_r <= 1'b0;
            cd_r <= l_cd;
            wr_n_r <= ~l_write;
            rd_n_r <= l_write;
            is_rd_r <= ~l_write;
            dout_r <= l_data;
            doe_n_r <= ~l_write;
            gap_r <= (mode_next_r | (left_r != 2'b00)) ?
                     usart_pkg::REC_INIT_CYC :
                     (sync_r ? usart_pkg::REC_SYNC_CYC :
                      usart_pkg::REC_ASYNC_CYC);
            cnt_r <= 5'h00;
            state_r <= usart_pkg::H_STB;
          end else begin
            ready_r <= ~init_go;
          end
        end
        usart_pkg::H_STB: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == usart_pkg::STROBE_CYC - 5'h01) begin
            if (is_rd_r) begin
              rsp_r <= bus.data_bus;
              rsp_valid_r <= 1'b1;
            end
            cs_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            doe_n_r <= 1'b1;
            cnt_r <= 5'h00;
            state_r <= usart_pkg::H_GAP;
          end
        end
        usart_pkg::H_GAP: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == gap_r - 5'h01) begin
            cnt_r <= 5'h00;
            state_r <= usart_pkg::H_IDLE;
          end
        end
        default: state_r <= usart_pkg::H_RST;
      endcase
    end
  end

  // Serial clock divider, period above the 1x and sync floors
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 6'h00;
      ser_clk_r <= 1'b0;
    end else if (div_r == usart_pkg::SER_HALF_CYC - 6'h01) begin
      div_r <= 6'h00;
      ser_clk_r <= ~ser_clk_r;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  assign bus.cs_n = cs_n_r;
  assign bus.rd_n = rd_n_r;
  assign bus.wr_n = wr_n_r;
  assign bus.cd = cd_r;
  assign bus.ext_reset = rst_r;
  assign bus.host_d = dout_r;
  assign bus.host_d_oe_n = doe_n_r;
  assign req_ready = ready_r;
  assign req_refused = refused_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_r;
  assign ser_clk = ser_clk_r;
endmodule

// ### testbench/usart_command_status_assertions.sv
// Checker on the host bus between the host and device ends.
// Assumes one ref_clk domain; instantiated beside the bus interface.
`timescale 1ns/100ps
module usart_command_status_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bus signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cd,
  input wire logic ext_reset,
  input wire logic txrdy,
  input wire logic host_d_oe_n,
  input wire logic [7:0] dev_d,
  input wire logic dev_d_oe_n,
  input wire logic [7:0] data_bus
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] gap_r;
  logic [2:0] wr_idx_r;
  logic wr_prev_r;
  // Idle cycles since the last write strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) gap_r <= 5'h1f;
    else if (!wr_n) gap_r <= 5'h00;
    else if (gap_r != 5'h1f) gap_r <= gap_r + 5'h01;
  end
  // Writes since the device reset pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) wr_prev_r <= 1'b1;
    else wr_prev_r <= wr_n;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) wr_idx_r <= 3'h0;
    else if (ext_reset) wr_idx_r <= 3'h0;
    else if (!wr_n && wr_prev_r && wr_idx_r != 3'h7)
      wr_idx_r <= wr_idx_r + 3'h1;
  end
  chk_reset_width_held: assert property (
    $fell(ext_reset) |-> $past(ext_reset, 6))
    else $error("device reset pulse too short");
  chk_init_zero_writes: assert property (
    $fell(wr_n) && wr_idx_r < 3'h3 |-> cd && data_bus == 8'h00)
    else $error("init write not a zero control write");
  chk_init_reset_cmd: assert property (
    $fell(wr_n) && wr_idx_r == 3'h3 |-> cd && data_bus == 8'h40)
    else $error("fourth init write not internal reset");
  chk_write_gap_kept: assert property (
    $fell(wr_n) |-> gap_r >= 5'h06)
    else $error("write recovery gap too short");
  // Mode bytes after an internal reset command with both bits set would also be caught here
  chk_hunt_error_clear: assert property (
    $fell(wr_n) && cd && wr_idx_r > 3'h4 && data_bus[2] && data_bus[7]
      |-> data_bus[4])
    else $error("hunt with receive enable lacks error clear");
  chk_data_write_ready: assert property (
    $fell(wr_n) && !cd |-> $past(txrdy))
    else $error("data written while transmitter not ready");
  chk_read_drive_bus: assert property (
    $fell(rd_n) && !cs_n |=> !dev_d_oe_n)
    else $error("device not driving read data");
  chk_read_release_bus: assert property (
    $rose(rd_n) |=> dev_d_oe_n)
    else $error("device holds bus after read");
  chk_status_frozen: assert property (
    !cs_n && !rd_n && cd && $past(!dev_d_oe_n) |-> $stable(dev_d))
    else $error("status changed during status read");
  chk_single_driver: assert property (
    !(!dev_d_oe_n && !host_d_oe_n))
    else $error("both ends drive the data bus");
  cov_status_read: cover property ($fell(rd_n) && cd);
  cov_data_write: cover property ($fell(wr_n) && !cd);
  cov_device_reset: cover property ($fell(ext_reset));
endmodule

// ### testbench/usart_command_status_test.sv
// Testbench joining host and device ends over the bus interface.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/100ps
module usart_command_status_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_char_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic rx_parity_err = 1'b0;
  logic rx_framing_err = 1'b0;
  logic sync_det_evt = 1'b0;
  logic tx_taken = 1'b0;
  logic tx_shift_empty = 1'b1;
  logic dsr_n = 1'b0;
  logic cts_n = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_cd = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic [7:0] mode_byte, sync_char1, sync_char2, cmd_bits, tx_char;
  logic hunt, tx_char_valid, rxrdy_pin, txempty_pin, syndet_pin;
  logic req_ready, req_refused, rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] st;
  logic dtr_n, rts_n, ser_clk;
  time ser_t;
  logic seen;
  int err_total = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  usart_bus_if bus_if ();
  usart_dev u_usart_dev (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus_if),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
    .sync_det_evt(sync_det_evt), .tx_taken(tx_taken),
    .tx_shift_empty(tx_shift_empty), .dsr_n(dsr_n), .cts_n(cts_n),
    .mode_byte(mode_byte), .sync_char1(sync_char1), .sync_char2(sync_char2),
    .cmd_bits(cmd_bits), .hunt(hunt), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .rxrdy_pin(rxrdy_pin),
    .txempty_pin(txempty_pin), .syndet_pin(syndet_pin), .dtr_n(dtr_n),
    .rts_n(rts_n));
  usart_host u_usart_host (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(bus_if), .req_valid(req_valid), .req_write(req_write),
    .req_cd(req_cd), .req_data(req_data), .req_ready(req_ready),
    .req_refused(req_refused), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .ser_clk(ser_clk));
  usart_command_status_assertions u_chk (.ref_clk(ref_clk),
    .reset_n(reset_n), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .cd(bus_if.cd), .ext_reset(bus_if.ext_reset),
    .txrdy(bus_if.txrdy), .host_d_oe_n(bus_if.host_d_oe_n),
    .dev_d(bus_if.dev_d), .dev_d_oe_n(bus_if.dev_d_oe_n),
    .data_bus(bus_if.data_bus));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples req_ready high
  task automatic host_req(input logic wr, input logic cd,
                          input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_cd <= cd;
    req_data <= d;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) err_total++;
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic host_read(input logic cd, output logic [7:0] d);
    int n;
    n = 0;
    host_req(1'b0, cd, 8'h00);
    @(negedge ref_clk);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) err_total++;
    d = rsp_data;
  endtask
  task automatic status_is(input logic [7:0] exp);
    host_read(1'b1, st);
    check(st, exp);
  endtask
  // Engine event pulse, then time for the flags to land
  task automatic rx_event(input logic [7:0] ch, input logic pe,
                          input logic fe);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char <= ch;
    rx_parity_err <= pe;
    rx_framing_err <= fe;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Async mode, then transmit and receive enabled
    host_req(1'b1, 1'b1, 8'h4e);
    host_req(1'b1, 1'b1, 8'h37);
    // Command lands one edge after the take, modem pins one more
    repeat (3) @(posedge ref_clk);
    check(mode_byte, 8'h4e);
    check(cmd_bits, 8'h37);
    check({6'h00, dtr_n, rts_n}, 8'h00);
    status_is(8'h85);
    check({7'h00, bus_if.txrdy}, 8'h00);
    // Serial clock period against the external sync clock ratio
    @(posedge ser_clk);
    ser_t = $time;
    @(posedge ser_clk);
    check({7'h00, ($time - ser_t) / 10 > usart_pkg::EXT_SYNC_RATIO},
          8'h01);
    $display("test setup done");
    @(posedge ref_clk);
    dsr_n <= 1'b1;
    cts_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    status_is(8'h05);
    check({7'h00, bus_if.txrdy}, 8'h01);
    check({7'h00, txempty_pin}, 8'h01);
    $display("test modem done");
    rx_event(8'h11, 1'b1, 1'b1);
    status_is(8'h2f);
    check({7'h00, rxrdy_pin}, 8'h01);
    rx_event(8'h22, 1'b0, 1'b0);
    status_is(8'h3f);
    host_read(1'b0, st);
    check(st, 8'h22);
    status_is(8'h3d);
    host_req(1'b1, 1'b1, 8'h37);
    status_is(8'h05);
    $display("test errors done");
    host_req(1'b1, 1'b0, 8'ha5);
    status_is(8'h00);
    check(tx_char, 8'ha5);
    check({7'h00, bus_if.txrdy}, 8'h00);
    seen = 1'b0;
    host_req(1'b1, 1'b0, 8'h5a);
    repeat (3) begin
      @(negedge ref_clk);
      seen = seen | (req_refused === 1'b1);
    end
    check({7'h00, seen}, 8'h01);
    check(tx_char, 8'ha5);
    @(posedge ref_clk);
    tx_taken <= 1'b1;
    @(posedge ref_clk);
    tx_taken <= 1'b0;
    repeat (3) @(posedge ref_clk);
    status_is(8'h05);
    $display("test transmit done");
    @(posedge ref_clk);
    sync_det_evt <= 1'b1;
    @(posedge ref_clk);
    sync_det_evt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({7'h00, syndet_pin}, 8'h01);
    status_is(8'h45);
    status_is(8'h05);
    $display("test sync detect done");
    // Internal reset, then sync mode with two sync characters
    host_req(1'b1, 1'b1, 8'h40);
    host_req(1'b1, 1'b1, 8'h00);
    host_req(1'b1, 1'b1, 8'h16);
    host_req(1'b1, 1'b1, 8'h3c);
    host_req(1'b1, 1'b1, 8'h84);
    repeat (2) @(posedge ref_clk);
    check(mode_byte, 8'h00);
    check(sync_char1, 8'h16);
    check(sync_char2, 8'h3c);
    check(cmd_bits, 8'h94);
    check({7'h00, hunt}, 8'h01);
    check({7'h00, bus_if.txrdy}, 8'h00);
    rx_event(8'h5a, 1'b0, 1'b1);
    status_is(8'h07);
    $display("test sync mode done");
    // Second reset clears the received character
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    status_is(8'h05);
    host_req(1'b1, 1'b1, 8'h4e);
    host_req(1'b1, 1'b1, 8'h01);
    repeat (3) @(posedge ref_clk);
    check(mode_byte, 8'h4e);
    check(cmd_bits, 8'h01);
    check({6'h00, dtr_n, rts_n}, 8'h03);
    $display("test reset done");
    finish_test();
  end
endmodule
